// >>> verilog/pbs_pkg.sv
// Purpose: shared constants and types of the pipelined burst memory core
// Assumes: one clock, commands sampled on the rising edge
// Notes: sizes below are fixed localparams; the top module can set only the core's own AW and NLANES
package pbs_pkg;
  localparam int ADDR_W = 18;
  localparam int LANES = 4;
  localparam int LANE_W = 9;
  localparam int DATA_W = LANES * LANE_W;
  localparam int PIPE_DEPTH = 2;
  localparam logic [1:0] BURST_START = 2'h0;
  localparam logic [1:0] BURST_STEP = 2'h1;

  typedef enum logic [2:0] {
    PBS_OP_IDLE = 3'b001,
    PBS_OP_READ = 3'b010,
    PBS_OP_WRITE = 3'b100
  } pbs_op_t;
endpackage

// >>> verilog/pbs_cmd_if.sv
// Purpose: decoded access passed from the command decoder to the core
// Assumes: one transfer per enabled clock edge
// Notes: the decoder drives, the core consumes
`timescale 1ns/1ps
interface pbs_cmd_if #(
  parameter int AW = 18
);
  logic [1:0] op;
  logic [AW-1:0] addr;
  logic selected;

  modport dec (output op, output addr, output selected);
  modport core (input op, input addr, input selected);
endinterface : pbs_cmd_if

// >>> verilog/pbs_cmd_decode.sv
// Purpose: decode one cycle's command and run the two-bit burst counter
// Assumes: inputs synchronous to clk
// Notes: op encoding on the interface: 0 idle, 1 read, 2 write
`timescale 1ns/1ps
module pbs_cmd_decode
  import pbs_pkg::*;
#(
  parameter int AW = 18
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic cycle_suspend_n,
  input wire logic advance_or_load,
  input wire logic read_not_write,
  input wire logic select_low_a,
  input wire logic select_low_b,
  input wire logic select_high,
  input wire logic burst_order_sel,
  input wire logic [AW-1:0] ext_addr,
  pbs_cmd_if.dec cmd
);
  import pbs_pkg::*;

  typedef struct packed {
    logic [AW-1:0] base;
    logic [1:0] count;
    logic [1:0] mode;
  } pbs_dec_state_t;

  pbs_dec_state_t st_q;
  pbs_dec_state_t st_d;
  logic sel;
  logic [1:0] next_count;
  logic [1:0] low_bits;

  // burst counter wraps on its own after the fourth address
  function automatic logic [1:0] burst_low(input logic [1:0] start, input logic [1:0] cnt,
                                           input logic interleaved);
    burst_low = interleaved ? (start ^ cnt) : 2'(start + cnt);
  endfunction

  always_comb begin
    sel = !select_low_a && !select_low_b && select_high; // RULE9
    next_count = 2'(st_q.count + BURST_STEP); // RULE19
    low_bits = burst_low(st_q.base[1:0], next_count, burst_order_sel); // RULE17 RULE18
    st_d = st_q;
    cmd.selected = sel;
    cmd.op = 2'h0;
    cmd.addr = ext_addr;
    if (!cycle_suspend_n) begin
      if (!advance_or_load) begin
        if (sel) begin
          st_d.base = ext_addr;
          st_d.count = BURST_START;
          st_d.mode = read_not_write ? 2'h1 : 2'h2; // RULE1 RULE2
        end else begin
          st_d.mode = 2'h0; // RULE7
        end
        cmd.op = sel ? st_d.mode : 2'h0;
      end else begin
        // chip selects and direction are ignored while advancing
        st_d.count = next_count; // RULE3 RULE4
        cmd.addr = {st_q.base[AW-1:2], low_bits};
        cmd.op = st_q.mode; // RULE5 RULE6
      end
    end
  end

  // no reset on the real part; nrst only gives a defined start
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d; // RULE10
    end
  end
endmodule : pbs_cmd_decode

// >>> verilog/pbs_core.sv
// Purpose: pipelined burst static memory core with two-cycle data latency
// Assumes: host drives commands and write data on the rising edge of clk
// Notes: data pin is split into in, out and output enable
//
// How it works
// RULE1: selected load with direction low starts write
// RULE2: selected load read drives data two edges later
// RULE3: advance high steps counter, uses internal address
// RULE4: advance ignores direction and selects
// RULE5: advance after write is another write
// RULE6: advance after deselect or idle is idle
// RULE7: load with any select false deselects
// RULE8: deselect floats bus two cycles later
// RULE9: selected needs both lows low, high high
// RULE10: suspended edge holds every register
// RULE11: suspend keeps data pins unchanged
// RULE12: bus floats after first edge from power-up
// RULE13: each strobe covers eight bits plus parity
// RULE14: any combination of lanes writes together
// RULE15: all strobes high writes nothing
// RULE16: narrow configuration has lanes one and two
// RULE17: burst order high means interleaved xor
// RULE18: burst order low means linear step
// RULE19: counter wraps to start and continues
// RULE20: back to back commands, no turnaround
// RULE21: host drives inputs synchronous to clock
// RULE22: asynchronous output enable gates read drive
`timescale 1ns/1ps
module pbs_core
  import pbs_pkg::*;
#(
  parameter int AW = 8,
  parameter int NLANES = LANES
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic cycle_suspend_n,
  input wire logic advance_or_load,
  input wire logic read_not_write,
  input wire logic select_low_a,
  input wire logic select_low_b,
  input wire logic select_high,
  input wire logic burst_order_sel,
  input wire logic output_enable_n,
  input wire logic [AW-1:0] ext_addr,
  input wire logic [NLANES-1:0] byte_lane_write_n,
  input wire logic [NLANES*LANE_W-1:0] data_in,
  output logic [NLANES*LANE_W-1:0] data_out,
  output logic data_oe
);
  import pbs_pkg::*;

  localparam int DW = NLANES * LANE_W;

  // ==========================================================
  // op decoding shared by the pipeline and the checks
  // codes on the command interface: 0 idle, 1 read, 2 write
  localparam logic [1:0] OP_IDLE = 2'h0;
  localparam logic [1:0] OP_READ = 2'h1;
  localparam logic [1:0] OP_WRITE = 2'h2;

  function automatic logic is_read(input logic [1:0] op);
    is_read = (op == OP_READ);
  endfunction

  function automatic logic is_write(input logic [1:0] op);
    is_write = (op == OP_WRITE);
  endfunction

  // ==========================================================
  // parameter checks
  initial begin
    if (NLANES != 2 && NLANES != LANES) begin
      $error("lane count must be 2 or 4"); // RULE16
    end
    if (AW < 2) begin
      $error("address needs at least the two burst bits");
    end
  end

  // ==========================================================
  // command decode
  pbs_cmd_if #(.AW(AW)) cmd ();

  pbs_cmd_decode #(.AW(AW)) u_dec (
    .clk(clk),
    .nrst(nrst),
    .cycle_suspend_n(cycle_suspend_n),
    .advance_or_load(advance_or_load),
    .read_not_write(read_not_write),
    .select_low_a(select_low_a),
    .select_low_b(select_low_b),
    .select_high(select_high),
    .burst_order_sel(burst_order_sel),
    .ext_addr(ext_addr),
    .cmd(cmd)
  );

  // ==========================================================
  // pipeline state
  typedef struct packed {
    logic [1:0] op1;
    logic [AW-1:0] addr1;
    logic [NLANES-1:0] wen1;
    logic [1:0] op2;
    logic [AW-1:0] addr2;
    logic [NLANES-1:0] wen2;
    logic [DW-1:0] rdata;
    logic drive;
  } pbs_core_state_t;

  pbs_core_state_t st_q;
  pbs_core_state_t st_d;
  logic [DW-1:0] mem_q [2**AW];
  logic do_write;
  wire logic [DW-1:0] merged;
  logic [DW-1:0] mem_word;
  logic fwd_hit;

  // lane merge: a lane takes bus data only where its strobe was low
  assign mem_word = mem_q[st_q.addr2];
  for (genvar g = 0; g < NLANES; g++) begin : g_lane
    assign merged[g*LANE_W +: LANE_W] = st_q.wen2[g] ? mem_word[g*LANE_W +: LANE_W] :
      data_in[g*LANE_W +: LANE_W]; // RULE13 RULE14
  end

  // the array takes a write at the same edge that loads read data, so a read
  // right behind a write to the same word takes the merged word instead
  assign fwd_hit = is_write(st_q.op2) && (st_q.addr2 == st_q.addr1);

  always_comb begin
    st_d = st_q;
    do_write = 1'b0;
    if (cycle_suspend_n) begin
      st_d = st_q; // RULE10 RULE11
    end else begin
      // stage one: command just taken, stage two: data phase of earlier command
      st_d.op1 = cmd.op; // RULE20
      st_d.addr1 = cmd.addr;
      st_d.wen1 = is_write(cmd.op) ? byte_lane_write_n : '1; // RULE15
      st_d.op2 = st_q.op1;
      st_d.addr2 = st_q.addr1;
      st_d.wen2 = st_q.wen1;
      // read data launched at the second edge after the command
      st_d.drive = is_read(st_q.op1); // RULE2 RULE8 RULE12
      if (is_read(st_q.op1)) begin
        st_d.rdata = fwd_hit ? merged : mem_q[st_q.addr1]; // RULE20
      end
      // write data is on the bus during the cycle after stage two fills
      do_write = is_write(st_q.op2) && !(&st_q.wen2); // RULE1 RULE5 RULE15
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // memory array is not reset, like the real cell array
  always_ff @(posedge clk) begin
    if (do_write) begin
      mem_q[st_q.addr2] <= merged;
    end
  end

  // ==========================================================
  // outputs
  // output enable acts without a clock, so the gate sits after the flop
  logic oe_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      oe_q <= 1'b0;
    end else begin
      oe_q <= st_d.drive;
    end
  end
  assign data_out = st_q.rdata;
  assign data_oe = oe_q & !output_enable_n; // RULE22

  // ==========================================================
  // checks
  logic en;
  assign en = !cycle_suspend_n;

  // burst start kept apart from the decoder, so the address checks do not
  // just repeat the decoder's own counter
  logic [AW-1:0] chk_base_q;
  logic [1:0] chk_step_q;
  logic [1:0] chk_mode_q;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      chk_base_q <= '0;
      chk_step_q <= 2'h0;
      chk_mode_q <= OP_IDLE;
    end else if (en && !advance_or_load) begin
      if (!select_low_a && !select_low_b && select_high) begin
        chk_base_q <= ext_addr;
        chk_step_q <= 2'h0;
        chk_mode_q <= read_not_write ? OP_READ : OP_WRITE;
      end else begin
        chk_mode_q <= OP_IDLE;
      end
    end else if (en) begin
      chk_step_q <= 2'(chk_step_q + 2'h1);
    end
  end

  AST_SUSPEND_HOLDS: assert property (@(posedge clk) disable iff (!nrst) // RULE10
    !en |=> $stable(st_q.op1) && $stable(st_q.op2) && $stable(st_q.rdata))
    else $error("state changed on suspended edge");
  AST_SUSPEND_PINS: assert property (@(posedge clk) disable iff (!nrst) // RULE11
    !en |=> oe_q == $past(oe_q))
    else $error("data drive changed while suspended");
  AST_READ_TWO_LATER: assert property (@(posedge clk) disable iff (!nrst) // RULE2
    en && !advance_or_load && read_not_write && cmd.selected ##1 en |=> oe_q)
    else $error("read not driven two edges later");
  AST_DESELECT_FLOAT: assert property (@(posedge clk) disable iff (!nrst) // RULE8
    en && !advance_or_load && !cmd.selected ##1 en |=> !oe_q)
    else $error("bus driven after deselect");
  AST_WRITE_FLOAT: assert property (@(posedge clk) disable iff (!nrst) // RULE1
    en && !advance_or_load && !read_not_write && cmd.selected ##1 en |=> !oe_q)
    else $error("bus driven in write data phase");
  AST_SELECT_AND: assert property (@(posedge clk) disable iff (!nrst) // RULE9
    en && !advance_or_load |->
      (cmd.op != OP_IDLE) == (!select_low_a && !select_low_b && select_high))
    else $error("select decode wrong");
  AST_NO_WRITE_MASKED: assert property (@(posedge clk) disable iff (!nrst) // RULE15
    &st_q.wen2 |-> !do_write)
    else $error("write with all strobes high");
  AST_ADV_KEEPS_MODE: assert property (@(posedge clk) disable iff (!nrst) // RULE4
    en && advance_or_load |-> cmd.op == chk_mode_q)
    else $error("advance did not follow burst direction");
  AST_OE_GATE: assert property (@(posedge clk) disable iff (!nrst) // RULE22
    output_enable_n |-> !data_oe)
    else $error("bus driven with output enable high");

  COV_READ: cover property (@(posedge clk) disable iff (!nrst) oe_q ##1 oe_q);
  COV_WRITE: cover property (@(posedge clk) disable iff (!nrst) do_write);
  COV_TURN: cover property (@(posedge clk) disable iff (!nrst) do_write ##1 oe_q);
  COV_SUSP: cover property (@(posedge clk) disable iff (!nrst) oe_q && !en);
  COV_WRAP: cover property (@(posedge clk) disable iff (!nrst)
    en && advance_or_load && chk_step_q == 2'h3);

  // ==========================================================
  // burst address checks
  AST_LOAD_EXT_ADDR: assert property (@(posedge clk) disable iff (!nrst) // RULE3
    en && !advance_or_load && cmd.selected |-> cmd.addr == ext_addr)
    else $error("load did not use the external address");

  AST_BURST_HIGH_BITS: assert property (@(posedge clk) disable iff (!nrst) // RULE3
    en && advance_or_load |-> cmd.addr[AW-1:2] == chk_base_q[AW-1:2])
    else $error("burst left its four word block");

  AST_BURST_LINEAR: assert property (@(posedge clk) disable iff (!nrst) // RULE18
    en && advance_or_load && !burst_order_sel |->
      cmd.addr[1:0] == 2'(chk_base_q[1:0] + chk_step_q + 2'h1))
    else $error("linear burst address wrong");

  AST_BURST_XOR: assert property (@(posedge clk) disable iff (!nrst) // RULE17
    en && advance_or_load && burst_order_sel |->
      cmd.addr[1:0] == (chk_base_q[1:0] ^ 2'(chk_step_q + 2'h1)))
    else $error("interleaved burst address wrong");

  AST_WRAP_CONTINUES: assert property (@(posedge clk) disable iff (!nrst) // RULE19
    en && advance_or_load && chk_step_q == 2'h3 |-> cmd.addr[1:0] == chk_base_q[1:0])
    else $error("burst did not wrap to its start");

  AST_ADV_AFTER_IDLE: assert property (@(posedge clk) disable iff (!nrst) // RULE6
    en && advance_or_load && chk_mode_q == OP_IDLE |-> cmd.op == OP_IDLE)
    else $error("advance after deselect started an access");

  // ==========================================================
  // data phase checks
  AST_WRITE_TWO_LATER: assert property (@(posedge clk) disable iff (!nrst) // RULE1
    en && is_write(cmd.op) && !(&byte_lane_write_n) ##1 en ##1 en |-> do_write)
    else $error("write not taken two edges later");

  AST_STROBES_TAKEN: assert property (@(posedge clk) disable iff (!nrst) // RULE5
    en && is_write(cmd.op) |=> st_q.wen1 == $past(byte_lane_write_n))
    else $error("strobes not taken with the write");

  AST_READ_MASK: assert property (@(posedge clk) disable iff (!nrst) // RULE15
    en && !is_write(cmd.op) |=> &st_q.wen1)
    else $error("strobes taken on a read or idle cycle");

  AST_SUSPEND_NO_WRITE: assert property (@(posedge clk) disable iff (!nrst) // RULE10
    !en |-> !do_write)
    else $error("array written on a suspended edge");

  AST_IDLE_NO_WRITE: assert property (@(posedge clk) disable iff (!nrst) // RULE8
    en && st_q.op2 == OP_IDLE |-> !do_write)
    else $error("array written in an idle data phase");

  AST_DATA_HOLD: assert property (@(posedge clk) disable iff (!nrst) // RULE11
    !en |=> $stable(data_out))
    else $error("read data changed while suspended");

  AST_DRIVE_READ: assert property (@(posedge clk) disable iff (!nrst) // RULE2
    en && is_read(st_q.op1) |=> oe_q)
    else $error("read data phase not driven");

  AST_WRITE_NO_DRIVE: assert property (@(posedge clk) disable iff (!nrst) // RULE20
    en && is_write(st_q.op1) |=> !oe_q)
    else $error("bus driven against write data");
endmodule : pbs_core

// >>> test/pbs_host.sv
// Purpose: host controller model for the burst memory core
// Assumes: drives at the rising edge, the core samples at the next one
// Notes: write data trails its command by two enabled edges
`timescale 1ns/1ps
module pbs_host
  import pbs_pkg::*;
(
  input wire logic clk,
  output logic cycle_suspend_n,
  output logic advance_or_load,
  output logic read_not_write,
  output logic select_low_a,
  output logic select_low_b,
  output logic select_high,
  output logic burst_order_sel,
  output logic [7:0] ext_addr,
  output logic [LANES-1:0] byte_lane_write_n,
  output logic [DATA_W-1:0] data_in
);
  logic [DATA_W-1:0] wd_q [2];
  logic wv_q [2];
  logic ord;
  initial begin
    {cycle_suspend_n, advance_or_load, read_not_write} = 3'h4;
    {select_low_a, select_low_b, select_high, burst_order_sel} = 4'hc;
    ext_addr = 8'h00;
    byte_lane_write_n = 4'hf;
    data_in = '0;
    wv_q = '{1'b0, 1'b0};
  end
  // ==========
  // one enabled slot; sel is {select_low_a, select_low_b, select_high}
  task automatic cyc(input logic adv, rnw, input logic [2:0] sel, input logic [3:0] bwn,
                     input logic [7:0] a, input logic wv, input logic [DATA_W-1:0] wd);
    @(posedge clk);
    cycle_suspend_n <= 1'b0;
    advance_or_load <= adv;
    read_not_write <= rnw;
    {select_low_a, select_low_b, select_high} <= sel;
    burst_order_sel <= ord;
    ext_addr <= a;
    byte_lane_write_n <= bwn;
    // a released bus must not keep showing the last word
    data_in <= wv_q[1] ? wd_q[1] : ~data_in;
    wd_q[1] = wd_q[0];
    wv_q[1] = wv_q[0];
    wd_q[0] = wd;
    wv_q[0] = wv;
  endtask
  // suspended slot: advance, address and data are scrambled since the core must ignore them
  task automatic hold();
    @(posedge clk);
    cycle_suspend_n <= 1'b1;
    advance_or_load <= ~advance_or_load;
    ext_addr <= ~ext_addr;
    data_in <= ~data_in;
  endtask
endmodule // pbs_host

// >>> test/pipelined_burst_sram_core_tb.sv
// Purpose: self-checking bench for the pipelined burst memory core
// Assumes: answers follow the second enabled edge after a command
// Notes: each slot judges the answer to the slot two calls earlier
`timescale 1ns/1ps
module pipelined_burst_sram_core_tb;
  import pbs_pkg::*;
  localparam logic [2:0] SEL = 3'h1;
  localparam logic [35:0] DA = 36'h1_2345_6789;
  localparam logic [35:0] DB = 36'h9_abcd_ef01;
  localparam logic [35:0] DC = 36'h5_5aa5_a55a;
  localparam logic [35:0] DD = 36'h3_c3c3_3c3c;
  localparam logic [35:0] DE = 36'he_0f1e_2d3c;
  localparam logic [35:0] M = 36'h0_07fc_01ff;
  localparam logic [35:0] DM = (DB & M) | (DA & ~M);
  logic clk, nrst, output_enable_n, data_oe;
  logic cycle_suspend_n, advance_or_load, read_not_write;
  logic select_low_a, select_low_b, select_high, burst_order_sel;
  logic [7:0] ext_addr;
  logic [LANES-1:0] byte_lane_write_n;
  logic [DATA_W-1:0] data_in, data_out;
  logic [DATA_W:0] q[$];
  logic [DATA_W:0] last;
  int n_mismatch, samples_checked;
  pbs_host u_host (.clk, .cycle_suspend_n, .advance_or_load, .read_not_write, .select_low_a,
    .select_low_b, .select_high, .burst_order_sel, .ext_addr, .byte_lane_write_n, .data_in);
  pbs_core #(.AW(8)) u_core (.clk, .nrst, .cycle_suspend_n, .advance_or_load, .read_not_write,
    .select_low_a, .select_low_b, .select_high, .burst_order_sel, .output_enable_n, .ext_addr,
    .byte_lane_write_n, .data_in, .data_out, .data_oe);
  // ==========
  // helpers; an expectation is {drive, word}, word ignored when not driven
  task automatic cmp(input logic [DATA_W:0] e);
    samples_checked++;
    if (data_oe !== e[DATA_W] || (e[DATA_W] && data_out !== e[DATA_W-1:0])) begin
      $display("Error at %0t: got %h expected %h", $time, {data_oe, data_out}, e);
      n_mismatch++;
    end
  endtask
  task automatic op(input logic adv, rnw, input logic [2:0] sel, input logic [3:0] bwn,
                    input logic [7:0] a, input logic wv, input logic [35:0] wd,
                    input logic [36:0] e);
    u_host.cyc(adv, rnw, sel, bwn, a, wv, wd);
    q.push_back(e);
    @(negedge clk);
    if (q.size() > 2) begin
      last = q.pop_front();
      cmp(last);
    end
  endtask
  task automatic hold(input logic oen, input logic [36:0] e);
    u_host.hold();
    output_enable_n <= oen;
    @(negedge clk);
    cmp(e);
  endtask
  task automatic wr(input logic [7:0] a, input logic [3:0] bwn, input logic [35:0] d);
    op(1'b0, 1'b0, SEL, bwn, a, 1'b1, d, '0);
  endtask
  // strobes held low on reads, they must not matter
  task automatic rd(input logic [7:0] a, input logic [35:0] d);
    op(1'b0, 1'b1, SEL, 4'h0, a, 1'b0, '0, {1'b1, d});
  endtask
  // advances carry opposite direction and false selects on purpose
  task automatic aw(input logic [35:0] d);
    op(1'b1, 1'b1, 3'h6, 4'h0, 8'hff, 1'b1, d, '0);
  endtask
  task automatic ar(input logic [35:0] d);
    op(1'b1, 1'b0, 3'h6, 4'h0, 8'hff, 1'b0, '0, {1'b1, d});
  endtask
  task automatic ds(input logic [2:0] sel);
    op(1'b0, 1'b0, sel, 4'h0, 8'h21, 1'b0, '0, '0);
  endtask
  // ==========
  // scenarios
  task automatic t_lanes();
    wr(8'h10, 4'h0, DA);
    wr(8'h10, 4'ha, DB);
    wr(8'h10, 4'hf, DC);
    ds(3'h5);
    ds(3'h3);
    wr(8'h12, 4'h0, DD);
    rd(8'h10, (DB & M) | (DA & ~M));
    ds(3'h0);
    rd(8'h12, DD);
    wr(8'h30, 4'h0, DC);
    rd(8'h30, DC);
    repeat (3) ds(3'h0);
  endtask
  task automatic t_burst();
    u_host.ord = 1'b0;
    wr(8'h21, 4'h0, DA);
    aw(DB);
    aw(DC);
    aw(DD);
    aw(DE);
    ds(3'h5);
    ds(3'h3);
    u_host.ord = 1'b1;
    rd(8'h21, DE);
    ar(DD);
    ar(DC);
    ar(DB);
    ar(DE);
    ds(3'h0);
    op(1'b1, 1'b0, SEL, 4'h0, 8'h22, 1'b1, DA, '0);
    repeat (3) ds(3'h0);
  endtask
  task automatic t_susp();
    rd(8'h10, DM);
    rd(8'h22, DB);
    hold(1'b0, {1'b1, DM});
    hold(1'b1, '0);
    hold(1'b0, {1'b1, DM});
    ds(3'h0);
    ds(3'h0);
    repeat (3) ds(3'h0);
  endtask
  task automatic give_verdict();
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    nrst = 1'b0;
    output_enable_n = 1'b0;
    u_host.ord = 1'b0;
    n_mismatch = 0;
    samples_checked = 0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    hold(1'b0, '0);
    t_lanes();
    t_burst();
    t_susp();
    give_verdict();
  end
endmodule // pipelined_burst_sram_core_tb
